// *** src/eraf_pkg.sv ***
package eraf_pkg;

    // register offsets (byte addresses)
    localparam logic [11:0] OFF_HASH_LOW   = 12'h080;
    localparam logic [11:0] OFF_HASH_HIGH  = 12'h084;
    localparam logic [11:0] OFF_SA1_LOW    = 12'h088;
    localparam logic [11:0] OFF_SA1_HIGH   = 12'h08C;
    localparam logic [11:0] OFF_TYPE1      = 12'h0A8;
    localparam logic [11:0] OFF_CFG        = 12'h000;
    localparam logic [11:0] OFF_STATUS     = 12'h004;

    // configuration field positions
    localparam int CFG_COPY_ALL_BIT  = 4;
    localparam int CFG_MC_HASH_BIT   = 6;
    localparam int CFG_UC_HASH_BIT   = 7;
    localparam int CFG_SA1_EN_BIT    = 8;
    localparam int CFG_KEEP_FCS_BIT  = 26;

    // type match field
    localparam int TYPE_EN_BIT       = 31;

    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // frame length limits
    localparam logic [13:0] MIN_FRAME_LEN = 14'h0040;
    localparam logic [13:0] MAX_FRAME_LEN = 14'h05EE;

    // frame summary handed over at end of frame
    typedef struct packed {
        logic [47:0] destAddr;
        logic [15:0] lenType;
        logic [13:0] length;
        logic        fcsErr;
        logic        phyErr;
    } eraf_frame_s;

    // match outcome
    typedef struct packed {
        logic saMatch;
        logic typeMatch;
        logic ucMatch;
        logic mcMatch;
        logic copyAll;
    } eraf_match_s;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_DECIDE = 3'b010,
        ST_DONE   = 3'b100
    } eraf_state_e;

endpackage : eraf_pkg

// *** src/eraf_hash_match.sv ***
`timescale 1ns/1ps
module eraf_hash_match (
    // frame address
    input  wire logic [47:0] destAddr,
    // settings
    input  wire logic [63:0] hashFilter,
    input  wire logic        ucHashEn,
    input  wire logic        mcHashEn,
    // results
    output logic       [5:0] hashIndex,
    output logic             ucMatch,
    output logic             mcMatch
);

    // xor of every sixth address bit, bit 0 is first-received lsb
    function automatic logic [5:0] fold(input logic [47:0] a);
        logic [5:0] r;
        r = 6'h00;
        for (int k = 0; k < 8; k++) begin
            r = r ^ a[k*6 +: 6];
        end
        return r;
    endfunction : fold

    logic hit;

    always_comb begin
        hashIndex = fold(destAddr);
        hit = hashFilter[hashIndex];
        mcMatch = mcHashEn && destAddr[0] && hit;
        ucMatch = ucHashEn && !destAddr[0] && hit;
    end

endmodule : eraf_hash_match

// *** src/eraf_rx_filter.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module eraf_rx_filter (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // register port
    input  wire logic          [11:0] regAddr,
    input  wire logic          [31:0] regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic               [31:0] regRdata,
    // frame from receive path
    input  wire logic                 frameValid,
    input  wire eraf_pkg::eraf_frame_s frameIn,
    // decision
    output logic                      frameCopy,
    output logic                      frameDrop,
    output eraf_pkg::eraf_match_s     matchInfo
);

    typedef struct packed {
        logic [31:0]           hashLow;
        logic [31:0]           hashHigh;
        logic [31:0]           sa1Low;
        logic [15:0]           sa1High;
        logic [31:0]           type1;
        logic [31:0]           cfg;
        logic [31:0]           rdata;
        eraf_pkg::eraf_frame_s frame;
        eraf_pkg::eraf_match_s match;
        eraf_pkg::eraf_state_e state;
        logic                  copy;
        logic                  drop;
        logic [15:0]           copied;
        logic [15:0]           dropped;
    } eraf_regs_s;

    eraf_regs_s st_r;
    eraf_regs_s st_nxt;

    logic [5:0] hashIndex;
    logic       ucMatch;
    logic       mcMatch;
    logic [63:0] hashVec;

    assign hashVec = {st_r.hashHigh, st_r.hashLow};

    eraf_hash_match u_hash (
        .destAddr   (st_r.frame.destAddr),
        .hashFilter (hashVec),
        .ucHashEn   (st_r.cfg[eraf_pkg::CFG_UC_HASH_BIT]),
        .mcHashEn   (st_r.cfg[eraf_pkg::CFG_MC_HASH_BIT]),
        .hashIndex  (hashIndex),
        .ucMatch    (ucMatch),
        .mcMatch    (mcMatch)
    );

    function automatic logic bad_len(input logic [13:0] len);
        return (len < eraf_pkg::MIN_FRAME_LEN) ||
               (len > eraf_pkg::MAX_FRAME_LEN);
    endfunction : bad_len

    logic saHit;
    logic typeHit;
    logic badFrame;
    logic anyMatch;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = eraf_pkg::RST_ZERO;
        st_nxt.copy = 1'b0;
        st_nxt.drop = 1'b0;
        saHit = st_r.cfg[eraf_pkg::CFG_SA1_EN_BIT] &&
                (st_r.frame.destAddr ==
                 {st_r.sa1High, st_r.sa1Low});
        typeHit = st_r.type1[eraf_pkg::TYPE_EN_BIT] &&
                  (st_r.frame.lenType == st_r.type1[15:0]);
        badFrame = bad_len(st_r.frame.length) || st_r.frame.phyErr ||
                   (st_r.frame.fcsErr &&
                    !st_r.cfg[eraf_pkg::CFG_KEEP_FCS_BIT]);
        anyMatch = saHit || typeHit || ucMatch || mcMatch ||
                   st_r.cfg[eraf_pkg::CFG_COPY_ALL_BIT];
        // register writes
        if (regWrite) begin
            if (regAddr == eraf_pkg::OFF_HASH_LOW) begin
                st_nxt.hashLow = regWdata;
            end else if (regAddr == eraf_pkg::OFF_HASH_HIGH) begin
                st_nxt.hashHigh = regWdata;
            end else if (regAddr == eraf_pkg::OFF_SA1_LOW) begin
                st_nxt.sa1Low = regWdata;
            end else if (regAddr == eraf_pkg::OFF_SA1_HIGH) begin
                st_nxt.sa1High = regWdata[15:0];
            end else if (regAddr == eraf_pkg::OFF_TYPE1) begin
                st_nxt.type1 = regWdata;
            end else if (regAddr == eraf_pkg::OFF_CFG) begin
                st_nxt.cfg = regWdata;
            end
        end
        // register reads, data one cycle later
        if (regRead) begin
            if (regAddr == eraf_pkg::OFF_HASH_LOW) begin
                st_nxt.rdata = st_r.hashLow;
            end else if (regAddr == eraf_pkg::OFF_HASH_HIGH) begin
                st_nxt.rdata = st_r.hashHigh;
            end else if (regAddr == eraf_pkg::OFF_SA1_LOW) begin
                st_nxt.rdata = st_r.sa1Low;
            end else if (regAddr == eraf_pkg::OFF_SA1_HIGH) begin
                st_nxt.rdata = {16'h0000, st_r.sa1High};
            end else if (regAddr == eraf_pkg::OFF_TYPE1) begin
                st_nxt.rdata = st_r.type1;
            end else if (regAddr == eraf_pkg::OFF_CFG) begin
                st_nxt.rdata = st_r.cfg;
            end else if (regAddr == eraf_pkg::OFF_STATUS) begin
                st_nxt.rdata = {st_r.dropped, st_r.copied};
            end
        end
        case (st_r.state)
            eraf_pkg::ST_IDLE: begin
                if (frameValid) begin
                    st_nxt.frame = frameIn;
                    st_nxt.state = eraf_pkg::ST_DECIDE;
                end
            end
            eraf_pkg::ST_DECIDE: begin
                st_nxt.match.saMatch = saHit;
                st_nxt.match.typeMatch = typeHit;
                st_nxt.match.ucMatch = ucMatch;
                st_nxt.match.mcMatch = mcMatch;
                st_nxt.match.copyAll =
                    st_r.cfg[eraf_pkg::CFG_COPY_ALL_BIT];
                if (anyMatch && !badFrame) begin
                    st_nxt.copy = 1'b1;
                    st_nxt.copied = st_r.copied + 16'h0001;
                end else begin
                    st_nxt.drop = 1'b1;
                    st_nxt.dropped = st_r.dropped + 16'h0001;
                end
                st_nxt.state = eraf_pkg::ST_DONE;
            end
            eraf_pkg::ST_DONE: begin
                st_nxt.state = eraf_pkg::ST_IDLE;
            end
            default: begin
                st_nxt.state = eraf_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.state <= eraf_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdata  = st_r.rdata;
    assign frameCopy = st_r.copy;
    assign frameDrop = st_r.drop;
    assign matchInfo = st_r.match;

    property p_copy_all;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE &&
         st_r.cfg[eraf_pkg::CFG_COPY_ALL_BIT] && !badFrame)
        |=> frameCopy;
    endproperty
    a_copy_all: assert property (p_copy_all)
        else $error("copy-all frame not copied");

    property p_bad_drop;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE && st_r.frame.phyErr)
        |=> frameDrop && !frameCopy;
    endproperty
    a_bad_drop: assert property (p_bad_drop)
        else $error("errored frame copied");

    property p_fcs_keep;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE && st_r.frame.fcsErr &&
         !st_r.cfg[eraf_pkg::CFG_KEEP_FCS_BIT]) |=> !frameCopy;
    endproperty
    a_fcs_keep: assert property (p_fcs_keep)
        else $error("fcs error frame copied without keep bit");

    property p_mc;
        @(posedge clk) disable iff (!resetn)
        mcMatch |-> st_r.frame.destAddr[0] &&
            st_r.cfg[eraf_pkg::CFG_MC_HASH_BIT];
    endproperty
    a_mc: assert property (p_mc)
        else $error("multicast match without cause");

    property p_uc;
        @(posedge clk) disable iff (!resetn)
        ucMatch |-> !st_r.frame.destAddr[0] &&
            st_r.cfg[eraf_pkg::CFG_UC_HASH_BIT];
    endproperty
    a_uc: assert property (p_uc)
        else $error("unicast match without cause");

    property p_hash_bit;
        @(posedge clk) disable iff (!resetn)
        (ucMatch || mcMatch) |-> hashVec[hashIndex];
    endproperty
    a_hash_bit: assert property (p_hash_bit)
        else $error("hash match on a clear filter bit");

    property p_type;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE &&
         st_r.type1[eraf_pkg::TYPE_EN_BIT] &&
         st_r.frame.lenType == st_r.type1[15:0] && !badFrame)
        |=> frameCopy && matchInfo.typeMatch;
    endproperty
    a_type: assert property (p_type)
        else $error("type match frame not copied");

    sequence s_decide;
        st_r.state == eraf_pkg::ST_DECIDE;
    endsequence

    property p_one_outcome;
        @(posedge clk) disable iff (!resetn)
        s_decide |=> (frameCopy ^ frameDrop) ##1 !(frameCopy | frameDrop);
    endproperty
    a_one_outcome: assert property (p_one_outcome)
        else $error("frame decision not a single pulse");

    property p_sa;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE &&
         st_r.cfg[eraf_pkg::CFG_SA1_EN_BIT] &&
         st_r.frame.destAddr == {st_r.sa1High, st_r.sa1Low} &&
         !badFrame)
        |=> frameCopy && matchInfo.saMatch;
    endproperty
    a_sa: assert property (p_sa)
        else $error("specific address frame not copied");

    property p_index_lo;
        @(posedge clk) disable iff (!resetn)
        hashIndex[0] == ^(st_r.frame.destAddr & 48'h0410_4104_1041);
    endproperty
    a_index_lo: assert property (p_index_lo)
        else $error("hash index bit 0 wrong");

    property p_index_hi;
        @(posedge clk) disable iff (!resetn)
        hashIndex[5] == ^(st_r.frame.destAddr & 48'h8208_2082_0820);
    endproperty
    a_index_hi: assert property (p_index_hi)
        else $error("hash index bit 5 wrong");

    property p_no_match;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE && !anyMatch)
        |=> frameDrop && !frameCopy;
    endproperty
    a_no_match: assert property (p_no_match)
        else $error("unmatched frame not dropped");

    property p_hash_copy;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE && (ucMatch || mcMatch) &&
         !badFrame) |=> frameCopy;
    endproperty
    a_hash_copy: assert property (p_hash_copy)
        else $error("hash matched frame not copied");

    property p_len_drop;
        @(posedge clk) disable iff (!resetn)
        (st_r.state == eraf_pkg::ST_DECIDE &&
         bad_len(st_r.frame.length)) |=> frameDrop && !frameCopy;
    endproperty
    a_len_drop: assert property (p_len_drop)
        else $error("frame of bad length copied");

    property p_copy_count;
        @(posedge clk) disable iff (!resetn)
        frameCopy |-> st_r.copied == $past(st_r.copied) + 16'h0001;
    endproperty
    a_copy_count: assert property (p_copy_count)
        else $error("copy counter not advanced");

endmodule : eraf_rx_filter

// *** test/eraf_frame_src.sv ***
`timescale 1ns/1ps
module eraf_frame_src (
    // clock
    input  wire logic             clk,
    // frame summary towards the filter
    output logic                  frameValid,
    output eraf_pkg::eraf_frame_s frameIn
);
    initial begin
        frameValid = 1'b0;
        frameIn    = '0;
    end
    // one summary per call; released bus shows the inverse
    task automatic send(input eraf_pkg::eraf_frame_s f);
        @(posedge clk);
        frameValid <= 1'b1;
        frameIn    <= f;
        @(posedge clk);
        frameValid <= 1'b0;
        frameIn    <= ~f;
    endtask : send
endmodule : eraf_frame_src

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic                  clk;
    logic                  resetn;
    logic [11:0]           regAddr;
    logic [31:0]           regWdata;
    logic                  regWrite;
    logic                  regRead;
    logic [31:0]           regRdata;
    logic                  frameValid;
    eraf_pkg::eraf_frame_s frameIn;
    logic                  frameCopy;
    logic                  frameDrop;
    eraf_pkg::eraf_match_s matchInfo;
    int                    failures;
    int                    num_checks;
    logic [47:0]           destAddrBits;

    eraf_rx_filter uut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .frameValid(frameValid), .frameIn(frameIn),
        .frameCopy(frameCopy), .frameDrop(frameDrop),
        .matchInfo(matchInfo));
    eraf_frame_src src (.clk(clk), .frameValid(frameValid),
        .frameIn(frameIn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wrap_up;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string n, input logic [63:0] s,
                         input logic [63:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %0h seen %0h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        check("regRdata", regRdata, e);
    endtask : rd

    function automatic logic [5:0] hidx(input logic [47:0] d);
        hidx = 6'h00;
        for (int i = 0; i < 48; i++) begin
            hidx[i % 6] ^= d[i];
        end
    endfunction : hidx

    task automatic frm(input logic [47:0] d, input logic e,
                       input logic [15:0] lt = 16'h0800,
                       input logic [13:0] ln = 14'h0064,
                       input logic fcs = 1'b0, input logic phy = 1'b0);
        src.send('{d, lt, ln, fcs, phy});
        @(posedge clk);
        #1;
        check("frameCopy", frameCopy, e);
        check("frameDrop", frameDrop, !e);
    endtask : frm

    task automatic t_regs;
        rd(eraf_pkg::OFF_HASH_LOW, 32'h0);
        rd(eraf_pkg::OFF_TYPE1, 32'h0);
        wr(eraf_pkg::OFF_HASH_LOW, 32'h1234_5678);
        wr(eraf_pkg::OFF_HASH_HIGH, 32'h9ABC_DEF0);
        wr(eraf_pkg::OFF_SA1_HIGH, 32'hFFFF_FFFF);
        wr(12'h0FC, 32'hFFFF_FFFF);
        rd(eraf_pkg::OFF_HASH_LOW, 32'h1234_5678);
        rd(eraf_pkg::OFF_HASH_HIGH, 32'h9ABC_DEF0);
        rd(eraf_pkg::OFF_SA1_HIGH, 32'h0000_FFFF);
        rd(12'h0FC, 32'h0);
    endtask : t_regs

    task automatic t_hash;
        logic [63:0] h;
        destAddrBits = 48'hA5C3_1E0F_7B92;
        h  = 64'h1 << hidx(destAddrBits);
        wr(eraf_pkg::OFF_HASH_LOW, h[31:0]);
        wr(eraf_pkg::OFF_HASH_HIGH, h[63:32]);
        wr(eraf_pkg::OFF_CFG, 32'h1 << eraf_pkg::CFG_UC_HASH_BIT);
        frm(destAddrBits, 1'b1);
        check("ucMatch", matchInfo.ucMatch, 1'b1);
        frm(destAddrBits ^ 48'h40, 1'b0);
        frm(destAddrBits | 48'h41, 1'b0);
        wr(eraf_pkg::OFF_CFG, 32'h1 << eraf_pkg::CFG_MC_HASH_BIT);
        frm(destAddrBits, 1'b0);
        frm(destAddrBits ^ 48'h41, 1'b1);
        check("mcMatch", matchInfo.mcMatch, 1'b1);
        wr(eraf_pkg::OFF_HASH_LOW, 32'hFFFF_FFFF);
        wr(eraf_pkg::OFF_HASH_HIGH, 32'hFFFF_FFFF);
        frm(48'h0000_0000_0003, 1'b1);
        frm(48'h0000_0000_0002, 1'b0);
    endtask : t_hash

    task automatic t_spec;
        wr(eraf_pkg::OFF_SA1_LOW, 32'h8765_4321);
        wr(eraf_pkg::OFF_SA1_HIGH, 32'h0000_CBA9);
        rd(eraf_pkg::OFF_SA1_LOW, 32'h8765_4321);
        wr(eraf_pkg::OFF_CFG, 32'h1 << eraf_pkg::CFG_SA1_EN_BIT);
        frm(48'hCBA9_8765_4321, 1'b1);
        check("saMatch", matchInfo.saMatch, 1'b1);
        frm(48'hCBA9_8765_4320, 1'b0);
        wr(eraf_pkg::OFF_TYPE1, 32'h8000_4321);
        rd(eraf_pkg::OFF_TYPE1, 32'h8000_4321);
        frm(48'h2, 1'b1, 16'h4321);
        check("typeMatch", matchInfo.typeMatch, 1'b1);
        frm(48'h2, 1'b0, 16'h4322);
        wr(eraf_pkg::OFF_TYPE1, 32'h0000_4321);
        frm(48'h2, 1'b0, 16'h4321);
    endtask : t_spec

    task automatic t_all;
        wr(eraf_pkg::OFF_CFG, 32'h1 << eraf_pkg::CFG_COPY_ALL_BIT);
        frm(48'h0F0E_0D0C_0B0A, 1'b1);
        check("copyAll", matchInfo.copyAll, 1'b1);
        frm(48'h2, 1'b1, 16'h0800, 14'h0040);
        frm(48'h2, 1'b1, 16'h0800, 14'h05EE);
        frm(48'h2, 1'b0, 16'h0800, 14'h003F);
        frm(48'h2, 1'b0, 16'h0800, 14'h05EF);
        frm(48'h2, 1'b0, 16'h0800, 14'h0064, 1'b1);
        frm(48'h2, 1'b0, 16'h0800, 14'h0064, 1'b0, 1'b1);
        wr(eraf_pkg::OFF_CFG, 32'h0400_0010);
        frm(48'h2, 1'b1, 16'h0800, 14'h0064, 1'b1);
        rd(eraf_pkg::OFF_CFG, 32'h0400_0010);
        rd(eraf_pkg::OFF_STATUS, 32'h000B_0009);
    endtask : t_all

    task automatic t_reset;
        @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk);
        #1;
        check("frameCopy", frameCopy, 1'b0);
        check("matchInfo", matchInfo, 64'h0);
        @(posedge clk);
        resetn <= 1'b1;
        rd(eraf_pkg::OFF_CFG, 32'h0);
        rd(eraf_pkg::OFF_STATUS, 32'h0);
        frm(48'h2, 1'b0);
    endtask : t_reset

    initial begin
        failures   = 0;
        num_checks = 0;
        resetn     = 1'b0;
        regAddr    = 12'h000;
        regWdata   = 32'h0;
        regWrite   = 1'b0;
        regRead    = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_hash();
        t_spec();
        t_all();
        t_reset();
        wrap_up();
    end

    initial begin
        #100000;
        failures++;
        wrap_up();
    end
endmodule : testbench
